// [src/pms_cfg.svh]
// register map, field positions, reset values and lock detector figures
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// ==============================================
// register indices (byte address = index * 4)
`define PMS_IDX_LOOP 6'h1C
`define PMS_IDX_BW 6'h1D
`define PMS_IDX_PROG 6'h1E

// ==============================================
// loop_control_reg fields
`define PMS_LC_IE 7
`define PMS_LC_FLAG 6
`define PMS_LC_PWR 5
`define PMS_LC_BCS 4
`define PMS_LC_UNUSED 4'hF

// ==============================================
// bandwidth_control_reg fields
`define PMS_BW_AUTO 7
`define PMS_BW_LOCK 6
`define PMS_BW_TRACK 5

// ==============================================
// reset values
`define PMS_RST_PWR 1'b1
`define PMS_RST_MULT 4'h6
`define PMS_RST_RANGE 4'h1

// ==============================================
// lock detector window (reference edges) and tolerances (feedback edges)
`define PMS_LOCK_WIN 8'h20
`define PMS_TOL_LOCK 8'h01
`define PMS_TOL_UNLOCK 8'h02
`define PMS_TOL_TRACK 8'h02
`define PMS_TOL_UNTRACK 8'h04

// ==============================================
// bus answers
`define PMS_RESP_OKAY 2'b00
`define PMS_RESP_SLVERR 2'b10

`endif

// [src/pms_clk_sel.sv]
// glitch-free base clock selector with divide by two
`timescale 1ns/1ps
`include "pms_cfg.svh"
module pms_clk_sel import pms_pkg::*; (
   input wire logic aclk,
   input wire logic aresetn,
   pms_ctl_if.sel c
);
   pms_sel_state_t state;
   logic [1:0] cnt;
   logic cur_vco;
   logic base_clk;
   wire logic old_tick = cur_vco ? c.vco_tick : c.xtal_tick;
   wire logic new_tick = cur_vco ? c.xtal_tick : c.vco_tick;
   wire logic want_change = (c.sel_req != cur_vco);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= SEL_STEADY;
         cnt <= 2'd0;
         cur_vco <= 1'b0;
         base_clk <= 1'b0;
      end else begin
         case (state)
            SEL_STEADY: begin
               cnt <= 2'd0;
               if (want_change) state <= SEL_DRAIN_OLD;
               else if (old_tick) base_clk <= ~base_clk;
            end
            SEL_DRAIN_OLD: begin
               if (!want_change) state <= SEL_STEADY;
               else if (old_tick) begin
                  cnt <= (cnt == 2'd2) ? 2'd0 : cnt + 2'd1;
                  if (cnt == 2'd2) state <= SEL_FILL_NEW;
               end
            end
            SEL_FILL_NEW: begin
               if (!want_change) state <= SEL_STEADY;
               else if (new_tick) begin
                  cnt <= (cnt == 2'd2) ? 2'd0 : cnt + 2'd1;
                  if (cnt == 2'd2) begin
                     cur_vco <= c.sel_req;
                     state <= SEL_STEADY;
                  end
               end
            end
            default: state <= SEL_STEADY;
         endcase
      end
   end

   assign c.sel_vco = cur_vco;
   assign c.busy = (state != SEL_STEADY);
   assign c.base_clk = base_clk;

   // ==============================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_stasis;
      state != SEL_STEADY |=> base_clk == $past(base_clk);
   endproperty
   a_stasis: assert property (p_stasis) else $error("base clock moved during switch");
   property p_halve;
      state == SEL_STEADY && !want_change && old_tick |=> base_clk != $past(base_clk);
   endproperty
   a_halve: assert property (p_halve) else $error("base clock missed a source edge");
   c_switch: cover property (state == SEL_FILL_NEW && new_tick && cnt == 2'd2);
endmodule // pms_clk_sel

// [src/pms_ctl_if.sv]
// signals between the control top, the lock detector and the clock selector
`timescale 1ns/1ps
interface pms_ctl_if;
   logic xtal_tick;
   logic vco_tick;
   logic det_enable;
   logic [3:0] mult_n;
   logic lock;
   logic track;
   logic sel_req;
   logic sel_vco;
   logic busy;
   logic base_clk;
   modport det(input xtal_tick, vco_tick, det_enable, mult_n, output lock, track);
   modport sel(input xtal_tick, vco_tick, sel_req, output sel_vco, busy, base_clk);
   modport top(output xtal_tick, vco_tick, det_enable, mult_n, sel_req,
               input lock, track, sel_vco, busy, base_clk);
endinterface

// [src/pms_lock_det.sv]
// lock detector: compares feedback and reference edge counts over a window
`timescale 1ns/1ps
`include "pms_cfg.svh"
module pms_lock_det import pms_pkg::*; #(
   parameter logic [7:0] WIN = `PMS_LOCK_WIN,
   parameter logic [7:0] TOL_LOCK = `PMS_TOL_LOCK,
   parameter logic [7:0] TOL_UNLOCK = `PMS_TOL_UNLOCK,
   parameter logic [7:0] TOL_TRACK = `PMS_TOL_TRACK,
   parameter logic [7:0] TOL_UNTRACK = `PMS_TOL_UNTRACK
) (
   input wire logic aclk,
   input wire logic aresetn,
   pms_ctl_if.det c
);
   pms_nib_t div_cnt;
   logic [7:0] ref_cnt;
   logic [7:0] fb_cnt;
   logic lock;
   logic track;
   wire pms_nib_t n_eff = (c.mult_n == 4'h0) ? 4'h1 : c.mult_n;
   wire logic div_wrap = (div_cnt == n_eff - 4'h1);
   wire logic fb_tick = c.vco_tick && div_wrap;
   wire logic win_end = c.xtal_tick && (ref_cnt == WIN - 8'h01);
   wire logic [7:0] fb_total = (fb_cnt == 8'hFF) ? fb_cnt : fb_cnt + {7'h00, fb_tick};
   wire logic [7:0] diff = (fb_total > WIN) ? fb_total - WIN : WIN - fb_total;

   always_ff @(posedge aclk) begin
      if (!aresetn || !c.det_enable) begin
         div_cnt <= 4'h0;
         ref_cnt <= 8'h00;
         fb_cnt <= 8'h00;
      end else begin
         if (c.vco_tick) div_cnt <= div_wrap ? 4'h0 : div_cnt + 4'h1;
         if (win_end) begin
            ref_cnt <= 8'h00;
            fb_cnt <= 8'h00;
         end else begin
            if (c.xtal_tick) ref_cnt <= ref_cnt + 8'h01;
            fb_cnt <= fb_total;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !c.det_enable) begin
         lock <= 1'b0;
         track <= 1'b0;
      end else if (win_end) begin
         if (diff <= TOL_LOCK) lock <= 1'b1;
         else if (diff > TOL_UNLOCK) lock <= 1'b0;
         if (diff <= TOL_TRACK) track <= 1'b1;
         else if (diff > TOL_UNTRACK) track <= 1'b0;
      end
   end

   assign c.lock = lock;
   assign c.track = track;

   // ==============================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_lock_off;
      !c.det_enable |=> !lock;
   endproperty
   a_lock_off: assert property (p_lock_off) else $error("lock held while detector off");
   property p_track_far;
      c.det_enable && win_end && diff > TOL_UNTRACK |=> !track;
   endproperty
   a_track_far: assert property (p_track_far) else $error("track kept outside tolerance");
endmodule // pms_lock_det

// [src/pms_loop_ctl.sv]
// loop mode, lock indication and base clock select control with AXI4-Lite registers
// Notes on behaviour
// - Acquisition mode shows the tracking-select bit as clear.
// - While the loop is active, filter tracks whenever not acquiring or the tracking-select bit is set.
// - Automatic bandwidth lets the lock detector choose the filter mode itself.
// - In automatic mode the tracking-select bit is read-only, showing the mode.
// - Automatic mode sets tracking inside track tolerance, clears outside untrack tolerance.
// - Automatic mode lock indicator sets inside lock tolerance, clears beyond unlock tolerance.
// - Lock-interrupt enable set: interrupt request on every lock indicator change.
// - Manual mode: tracking-select bit is written and directly picks the filter mode.
// - Manual mode disables the lock indicator and all interrupt requests.
// - Program register: multiplier in upper nibble, range in lower nibble.
// - Multiplier zero acts as multiplier one at vco_mult and in the lock detector, but reads back as zero.
// - Range zero disables the loop and drops the VCO request, but a switch back from the VCO then stalls with VCO edges gated off.
// - Source change waits three edges of each clock, base clock held static.
// - Switched clock is divided by two to make the base clock.
// - VCO source selection is refused while the loop is off.
// - Turning the loop off is refused while the VCO source is selected.
// - One write can change both loop power and source only when it turns the loop off and sets the source select, or from that state turns both back.
// - Lock-change flag sets on indicator toggle, a loop control register read clears it.
// - Manual mode: lock-interrupt enable ignores writes, reads zero; reset clears.
// - Source select one picks VCO, zero crystal; reset and stop clear it.
`timescale 1ns/1ps
`include "pms_cfg.svh"
module pms_loop_ctl import pms_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic crystal_clock,
   input wire logic vco_clock,
   input wire logic stop_req,
   output logic base_clock,
   output logic vco_selected,
   output logic loop_enable,
   output logic filter_track,
   output pms_nib_t vco_mult,
   output pms_nib_t vco_range,
   output logic lock_irq
);
   pms_ctl_if c();

   // ==============================================
   // register state
   logic lock_irq_enable;
   logic lock_change_flag;
   logic loop_power_on;
   logic base_source_select;
   logic bw_auto;
   logic acq_manual;
   logic lock_prev;
   pms_nib_t prog_mult;
   pms_nib_t prog_range;

   // ==============================================
   // source edge detection
   logic xtal_d;
   logic vco_d;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xtal_d <= 1'b1;
         vco_d <= 1'b1;
      end else begin
         xtal_d <= crystal_clock;
         vco_d <= vco_clock;
      end
   end

   wire logic loop_active = loop_power_on && (prog_range != 4'h0);
   wire logic lock_seen = bw_auto && c.lock;
   wire logic track_now = bw_auto ? c.track : acq_manual;

   assign c.xtal_tick = crystal_clock && !xtal_d;
   assign c.vco_tick = vco_clock && !vco_d && loop_active;
   assign c.det_enable = bw_auto && loop_active;
   assign c.mult_n = prog_mult;
   assign c.sel_req = base_source_select && loop_active;

   pms_lock_det u_det (
      .aclk(aclk),
      .aresetn(aresetn),
      .c(c.det)
   );

   pms_clk_sel u_sel (
      .aclk(aclk),
      .aresetn(aresetn),
      .c(c.sel)
   );

   // ==============================================
   // AXI4-Lite write channel
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   wire logic aw_take = s_axi_awvalid && s_axi_awready;
   wire logic w_take = s_axi_wvalid && s_axi_wready;
   wire logic do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire logic [5:0] wr_idx = aw_addr_q[7:2];
   wire logic wr_hit = (wr_idx == `PMS_IDX_LOOP) || (wr_idx == `PMS_IDX_BW)
                       || (wr_idx == `PMS_IDX_PROG);
   wire logic wr_loop = do_write && w_strb_q[0] && (wr_idx == `PMS_IDX_LOOP);
   wire logic wr_bw = do_write && w_strb_q[0] && (wr_idx == `PMS_IDX_BW);
   wire logic wr_prog = do_write && w_strb_q[0] && (wr_idx == `PMS_IDX_PROG);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMS_RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            s_axi_wready <= 1'b0;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ==============================================
   // AXI4-Lite read channel
   wire logic ar_take = s_axi_arvalid && s_axi_arready;
   wire logic [5:0] rd_idx = s_axi_araddr[7:2];
   wire logic rd_loop = ar_take && (rd_idx == `PMS_IDX_LOOP);
   wire logic [7:0] loop_rd = {lock_irq_enable, bw_auto && lock_change_flag,
                               loop_power_on, base_source_select, `PMS_LC_UNUSED};
   wire logic [7:0] bw_rd = {bw_auto, lock_seen, track_now, 5'h00};
   wire logic [7:0] rd_byte = (rd_idx == `PMS_IDX_LOOP) ? loop_rd
                            : (rd_idx == `PMS_IDX_BW) ? bw_rd
                            : (rd_idx == `PMS_IDX_PROG) ? {prog_mult, prog_range}
                            : 8'h00;
   wire logic rd_hit = (rd_idx == `PMS_IDX_LOOP) || (rd_idx == `PMS_IDX_BW)
                       || (rd_idx == `PMS_IDX_PROG);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `PMS_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_byte};
         s_axi_rresp <= rd_hit ? `PMS_RESP_OKAY : `PMS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ==============================================
   // control register next values
   wire logic next_bcs = stop_req ? 1'b0
                       : !wr_loop ? base_source_select
                       : w_data_q[`PMS_LC_BCS] && loop_power_on && (prog_range != 4'h0);
   wire logic next_pwr = !wr_loop ? loop_power_on
                       : (w_data_q[`PMS_LC_PWR] || base_source_select);
   wire logic next_ie = !bw_auto ? 1'b0
                      : wr_loop ? w_data_q[`PMS_LC_IE] : lock_irq_enable;
   wire logic lock_toggle = bw_auto && (c.lock != lock_prev);
   wire logic next_flag = lock_toggle || (lock_change_flag && !rd_loop);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_irq_enable <= 1'b0;
         lock_change_flag <= 1'b0;
         loop_power_on <= `PMS_RST_PWR;
         base_source_select <= 1'b0;
         lock_prev <= 1'b0;
      end else begin
         lock_irq_enable <= next_ie;
         lock_change_flag <= next_flag;
         loop_power_on <= next_pwr;
         base_source_select <= next_bcs;
         lock_prev <= c.lock;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bw_auto <= 1'b0;
         acq_manual <= 1'b0;
      end else if (wr_bw) begin
         bw_auto <= w_data_q[`PMS_BW_AUTO];
         if (!bw_auto) acq_manual <= w_data_q[`PMS_BW_TRACK];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prog_mult <= `PMS_RST_MULT;
         prog_range <= `PMS_RST_RANGE;
      end else if (wr_prog) begin
         if (!loop_power_on) prog_mult <= w_data_q[7:4];
         prog_range <= w_data_q[3:0];
      end
   end

   // ==============================================
   // outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         loop_enable <= 1'b0;
         filter_track <= 1'b0;
         lock_irq <= 1'b0;
         vco_mult <= 4'h0;
         vco_range <= 4'h0;
         vco_selected <= 1'b0;
      end else begin
         loop_enable <= loop_active;
         filter_track <= loop_active && track_now;
         lock_irq <= bw_auto && lock_irq_enable && lock_change_flag;
         vco_mult <= (prog_mult == 4'h0) ? 4'h1 : prog_mult;
         vco_range <= prog_range;
         vco_selected <= c.sel_vco;
      end
   end
   assign base_clock = c.base_clk;

   // ==============================================
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bcs_needs_power;
      wr_loop && !stop_req && !loop_power_on |=> !base_source_select;
   endproperty
   a_bcs_needs_power: assert property (p_bcs_needs_power) else $error("vco chosen with loop off");
   property p_power_held;
      wr_loop && base_source_select && !w_data_q[`PMS_LC_PWR] |=> loop_power_on;
   endproperty
   a_power_held: assert property (p_power_held) else $error("loop turned off on vco");
   property p_one_change;
      wr_loop |=> !($changed(loop_power_on) && $changed(base_source_select));
   endproperty
   a_one_change: assert property (p_one_change) else $error("power and source changed together");
   property p_flag_set;
      bw_auto && c.lock != lock_prev |=> lock_change_flag;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("lock toggle lost");
   property p_flag_rd;
      rd_loop && !lock_toggle |=> !lock_change_flag;
   endproperty
   a_flag_rd: assert property (p_flag_rd) else $error("flag not cleared by read");
   property p_ie_manual;
      !bw_auto |=> !lock_irq_enable;
   endproperty
   a_ie_manual: assert property (p_ie_manual) else $error("irq enable set in manual mode");
   property p_irq_manual;
      !bw_auto |=> !lock_irq;
   endproperty
   a_irq_manual: assert property (p_irq_manual) else $error("irq raised in manual mode");
   property p_irq_on;
      bw_auto && lock_irq_enable && lock_change_flag |=> lock_irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("lock change irq missing");
   property p_range_zero;
      prog_range == 4'h0 |=> !loop_enable && !filter_track;
   endproperty
   a_range_zero: assert property (p_range_zero) else $error("loop active with range zero");
   property p_stop;
      stop_req |=> !base_source_select;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not clear source select");
   property p_acq_clear;
      loop_active && bw_auto && !c.track |=> !filter_track;
   endproperty
   a_acq_clear: assert property (p_acq_clear) else $error("tracking shown during acquisition");
   property p_track_ro;
      wr_bw && bw_auto |=> acq_manual == $past(acq_manual);
   endproperty
   a_track_ro: assert property (p_track_ro) else $error("track select written in auto");
   property p_lock_rd;
      ar_take && rd_idx == `PMS_IDX_BW && !bw_auto |=> !s_axi_rdata[`PMS_BW_LOCK];
   endproperty
   a_lock_rd: assert property (p_lock_rd) else $error("lock shown in manual mode");
   property p_ie_write;
      wr_loop && bw_auto |=> lock_irq_enable == $past(w_data_q[`PMS_LC_IE]);
   endproperty
   a_ie_write: assert property (p_ie_write) else $error("irq enable write lost");
   property p_irq_off;
      !lock_irq_enable |=> !lock_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq raised while disabled");
   property p_mult_lock;
      wr_prog && loop_power_on |=> prog_mult == $past(prog_mult);
   endproperty
   a_mult_lock: assert property (p_mult_lock) else $error("multiplier changed with loop on");
   property p_mult_eff;
      prog_mult == 4'h0 |=> vco_mult == 4'h1;
   endproperty
   a_mult_eff: assert property (p_mult_eff) else $error("multiplier zero not shown as one");
   property p_bcs_range;
      wr_loop && prog_range == 4'h0 |=> !base_source_select;
   endproperty
   a_bcs_range: assert property (p_bcs_range) else $error("vco chosen with range zero");
   property p_manual_track;
      loop_active && !bw_auto && acq_manual |=> filter_track;
   endproperty
   a_manual_track: assert property (p_manual_track) else $error("manual track ignored");
   property p_auto_track;
      loop_active && bw_auto && c.track |=> filter_track;
   endproperty
   a_auto_track: assert property (p_auto_track) else $error("detector track ignored");
   c_irq: cover property (!lock_irq ##1 lock_irq);
   c_vco: cover property (!vco_selected ##1 vco_selected);
   c_rd_clr: cover property (lock_change_flag && rd_loop);
endmodule // pms_loop_ctl

// [src/pms_pkg.sv]
// types shared by the loop control block
package pms_pkg;
   typedef logic [3:0] pms_nib_t;
   typedef enum logic [1:0] {SEL_STEADY, SEL_DRAIN_OLD, SEL_FILL_NEW} pms_sel_state_t;
endpackage

// [tb/pms_clk_src.sv]
// crystal source and a vco that runs only while the loop is active
`timescale 1ns/1ps
module pms_clk_src (
   input wire logic aclk,
   input wire logic run,
   input wire logic [3:0] vhalf,
   output logic crystal_clock,
   output logic vco_clock
);
   logic [4:0] xc;
   logic [3:0] vc;
   initial begin
      xc = 5'h00;
      vc = 4'h0;
      crystal_clock = 1'b0;
      vco_clock = 1'b0;
   end
   // crystal period 36 cycles; vco period 2*vhalf, frozen while the loop is off
   always @(posedge aclk) begin
      xc <= (xc == 5'h11) ? 5'h00 : xc + 5'h01;
      if (xc == 5'h11) crystal_clock <= ~crystal_clock;
      vc <= (!run || vc == vhalf - 4'h1) ? 4'h0 : vc + 4'h1;
      if (run && vc == vhalf - 4'h1) vco_clock <= ~vco_clock;
   end
endmodule // pms_clk_src

// [tb/pms_loop_ctl_tb.sv]
// self-checking bench for the loop control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module pms_loop_ctl_tb import pms_pkg::*; ;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stop_req;
   logic awready, wready, bvalid, arready, rvalid, base_clock, vco_selected;
   logic loop_enable, filter_track, lock_irq, crystal_clock, vco_clock;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [3:0] vhalf;
   pms_nib_t vco_mult, vco_range;
   int n_mismatch, n_compared, i;
   pms_loop_ctl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .crystal_clock(crystal_clock),
      .vco_clock(vco_clock), .stop_req(stop_req), .base_clock(base_clock),
      .vco_selected(vco_selected), .loop_enable(loop_enable), .filter_track(filter_track),
      .vco_mult(vco_mult), .vco_range(vco_range), .lock_irq(lock_irq));
   pms_clk_src src (.aclk(aclk), .run(loop_enable), .vhalf(vhalf),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock));
   // ==========================================
   // bus tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask
   task automatic chkr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
      rdr(a);
      `CHK("rdata", {24'h00_0000, e}, rd)
      `CHK("rresp", er, rs)
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // cycles between two base clock toggles
   task automatic halfp(input int e);
      logic b;
      int c;
      @(posedge aclk);
      b = base_clock;
      for (c = 0; c < 200 && base_clock === b; c++) @(posedge aclk);
      b = base_clock;
      for (c = 0; c < 200 && base_clock === b; c++) @(posedge aclk);
      `CHK("base half period", e, c)
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset;
      chkr(8'h70, 8'h2F, 2'b00);
      chkr(8'h74, 8'h00, 2'b00);
      chkr(8'h78, 8'h61, 2'b00);
      chkr(8'h7C, 8'h00, 2'b10);
      wr(8'h7C, 8'hFF, 2'b10);
      `CHK("mult", 4'h6, vco_mult)
   endtask
   task automatic t_manual;
      tick(20);
      wr(8'h74, 8'h20, 2'b00);
      tick(2);
      `CHK("track", 1'b1, filter_track)
      chkr(8'h74, 8'h20, 2'b00);
      wr(8'h70, 8'hA0, 2'b00);
      chkr(8'h70, 8'h2F, 2'b00);
      `CHK("irq", 1'b0, lock_irq)
      wr(8'h74, 8'h00, 2'b00);
      tick(2);
      `CHK("track", 1'b0, filter_track)
      wr(8'h70, 8'h00, 2'b00);
      tick(2);
      `CHK("loop", 1'b0, loop_enable)
      wr(8'h70, 8'h30, 2'b00);
      chkr(8'h70, 8'h2F, 2'b00);
   endtask
   task automatic t_auto;
      wr(8'h74, 8'h80, 2'b00);
      wr(8'h70, 8'hA0, 2'b00);
      for (i = 0; i < 5000 && lock_irq !== 1'b1; i++) @(posedge aclk);
      `CHK("irq", 1'b1, lock_irq)
      wr(8'h74, 8'h80, 2'b00);
      chkr(8'h74, 8'hE0, 2'b00);
      `CHK("track", 1'b1, filter_track)
      chkr(8'h70, 8'hEF, 2'b00);
      chkr(8'h70, 8'hAF, 2'b00);
      `CHK("irq", 1'b0, lock_irq)
   endtask
   task automatic t_vco;
      wr(8'h70, 8'hB0, 2'b00);
      for (i = 0; i < 300 && vco_selected !== 1'b1; i++) @(posedge aclk);
      `CHK("vco sel", 1'b1, vco_selected)
      halfp(6);
      wr(8'h70, 8'h90, 2'b00);
      chkr(8'h70, 8'hBF, 2'b00);
      vhalf <= 4'h4;
      for (i = 0; i < 5000 && lock_irq !== 1'b1; i++) @(posedge aclk);
      `CHK("irq", 1'b1, lock_irq)
      // one full detector window at the new rate, so track has settled too
      tick(1200);
      chkr(8'h74, 8'h80, 2'b00);
      chkr(8'h70, 8'hFF, 2'b00);
      stop_req <= 1'b1;
      @(posedge aclk);
      stop_req <= 1'b0;
      for (i = 0; i < 300 && vco_selected !== 1'b0; i++) @(posedge aclk);
      `CHK("vco sel", 1'b0, vco_selected)
      halfp(36);
      vhalf <= 4'h3;
   endtask
   task automatic t_prog;
      wr(8'h78, 8'h60, 2'b00);
      tick(2);
      `CHK("loop", 1'b0, loop_enable)
      `CHK("range", 4'h0, vco_range)
      wr(8'h70, 8'hB0, 2'b00);
      rdr(8'h70);
      `CHK("bcs", 1'b0, rd[4])
      wr(8'h70, 8'h00, 2'b00);
      wr(8'h78, 8'h01, 2'b00);
      tick(2);
      `CHK("mult", 4'h1, vco_mult)
      chkr(8'h78, 8'h01, 2'b00);
   endtask
   // ==========================================
   // run control
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      end_sim;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, stop_req} = 7'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0000_0000;
      vhalf = 4'h3;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_manual;
      t_auto;
      t_vco;
      t_prog;
      end_sim;
   end
endmodule // pms_loop_ctl_tb
